// >>> irq_params.svh
/*
  Constants for the cascaded interrupt controller pair: port addresses, command field
  positions, reset values.
  Assumes it is included by bare name into the design file and the checker.
*/
// Overview of operation
// - base write with bit 4 set always restarts initialization as word 1
// - three base+1 writes follow, taken as init words 2, 3, 4 in order
// - word 1 clears mask, lowest priority to line 7, special mask off, read request
// - later base writes: bits 4:3 00 is eoi/rotate word, 01 read-select word
// - init word 2 gives vector bits 7:3; low three bits written zero
// - word 4 bit 4 selects special fully nested mode, acted on by the master only; bit 0 written one
// - word 4 bit 1 selects automatic end of interrupt
// - a set mask bit keeps its line from setting the request bit
// - a read of base+1 returns the mask register directly
// - master line 2 mask also blocks all slave requests
// - masking a higher line leaves lower lines handled normally
// - eoi/rotate word bits 7:5 decode into eoi, rotate and priority commands
// - with select-level bit 6 set, bits 2:0 name the level acted on
// - after reset or init: fully nested, no rotation, no specific eoi
// - read-select bit 5 enables bit 6 to set or clear special mask mode
// - read-select bit 2 makes next read a poll acknowledge
// - bits 1:0 choose request or in-service reads; selection persists
// - master trigger register at 4D0h resets 00h; lines 0..2 stay edge
// - slave trigger register 4D1h programs lines 15,14,12..9; 13 and 8 edge
// - a level-mode line is active while its input stays high
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH
`define ADDR_MASTER_BASE   16'h0020
`define ADDR_MASTER_DATA   16'h0021
`define ADDR_SLAVE_BASE    16'h00A0
`define ADDR_SLAVE_DATA    16'h00A1
`define ADDR_MASTER_TRIG   16'h04D0
`define ADDR_SLAVE_TRIG    16'h04D1
`define BIT_INIT           4
`define BIT_SEL_LEVEL      6
`define SEL_EOI_ROTATE     2'h0
`define SEL_READ_SELECT    2'h1
`define CMD_CLR_AUTO_ROT   3'h0
`define CMD_NS_EOI         3'h1
`define CMD_NOP            3'h2
`define CMD_SP_EOI         3'h3
`define CMD_SET_AUTO_ROT   3'h4
`define CMD_ROT_NS_EOI     3'h5
`define CMD_SET_PRIO       3'h6
`define CMD_ROT_SP_EOI     3'h7
`define W4_SPECIAL_FULLY_NESTED_BIT        4
`define W4_AUTOMATIC_END_OF_INTERRUPT_BIT        1
`define RS_POLL_BIT        2
`define RS_SPECIAL_MASK_ENABLE_BIT        5
`define RS_SMM_BIT         6
`define RESET_MASK         8'h00
`define RESET_TRIG         8'h00
`define RESET_LOWEST       3'h7
`define MASTER_TRIG_OK     8'hF8
`define SLAVE_TRIG_OK      8'hDE
`define CASCADE_LINE       2
`define CASCADE_ID         3'h2
`endif

// >>> irq_pkg.sv
/*
  Types for the cascaded interrupt controller.
  Assumes the params header is available for inclusion.
*/
package irq_pkg;
  // init sequence position, one-hot
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_W2  = 4'h2,
    ST_W3  = 4'h4,
    ST_W4  = 4'h8
  } init_state_t;
endpackage : irq_pkg

// >>> cascaded_irq_ctrl.sv
/*
  Pair of cascaded legacy interrupt controllers reached by I/O reads and writes.
  Assumes one 25 MHz clock, single-cycle io strobes from logic on that clock and
  request pins that are asynchronous and pass a three-stage synchroniser.
*/
`timescale 1ns/1ns
`include "irq_params.svh"

module cascaded_irq_ctrl
  import irq_pkg::*;
#(
  parameter int LINES = 8
)(
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_B_IN,
  input  wire logic [15:0] IO_ADDR_IN,
  input  wire logic [7:0]  IO_WDATA_IN,
  input  wire logic        IO_WR_IN,
  input  wire logic        IO_RD_IN,
  input  wire logic        INTA_IN,
  input  wire logic [15:0] IRQ_IN,
  output logic      [7:0]  IO_RDATA_OUT,
  output logic             IO_RVALID_OUT,
  output logic             CPU_IRQ_OUT,
  output logic      [7:0]  VECTOR_OUT
);

  // three-stage synchroniser; stage one feeds stage two only
  logic [15:0] s1_r, s2_r, s3_r;
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      s1_r <= 16'h0000;
      s2_r <= 16'h0000;
      s3_r <= 16'h0000;
    end
    else
    begin
      s1_r <= IRQ_IN;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // the settled level only changes once stages two and three agree
  logic [15:0] lvl_r;
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      lvl_r <= 16'h0000;
    else
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
  end

  logic [15:0] lvl_d_r;
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      lvl_d_r <= 16'h0000;
    else
      lvl_d_r <= lvl_r;
  end

  // trigger-type registers; unprogrammable bits forced to zero
  logic [7:0] trig_m_r, trig_s_r;
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      trig_m_r <= `RESET_TRIG;
      trig_s_r <= `RESET_TRIG;
    end
    else if (IO_WR_IN)
    begin
      if (IO_ADDR_IN == `ADDR_MASTER_TRIG)
        trig_m_r <= IO_WDATA_IN & `MASTER_TRIG_OK;
      if (IO_ADDR_IN == `ADDR_SLAVE_TRIG)
        trig_s_r <= IO_WDATA_IN & `SLAVE_TRIG_OK;
    end
  end

  wire logic [1:0]       inta_take;
  wire logic [1:0][2:0]  take_lvl;
  wire logic [1:0]       take_any;
  wire logic [1:0][7:0]  rd_val;
  wire logic [1:0][4:0]  vec_hi;
  wire logic [1:0]       poll_read;
  logic                  cpu_from_slave;
  logic                  slave_prev_r;

  // one generate entry per controller: 0 master, 1 slave
  for (genvar c = 0; c < 2; c++)
  begin : g_ctl
    localparam logic [15:0] BASE = (c == 0) ? `ADDR_MASTER_BASE : `ADDR_SLAVE_BASE;
    localparam logic [15:0] DATA = (c == 0) ? `ADDR_MASTER_DATA : `ADDR_SLAVE_DATA;
    init_state_t st_r;
    logic [7:0] mask_r, irr_r, isr_r;
    logic [4:0] vbase_r;
    logic [2:0] low_r;
    logic       special_fully_nested_r, automatic_end_of_interrupt_r, autorot_r, smm_r, rsel_r, poll_r;
    logic       wr_base, wr_data, init_w;
    logic [7:0] req, edge_hit, lvl_on, trig, in_lvl, in_prev, eoi_clr, rd_loc;
    logic [2:0] hi_lvl, srv_lvl, cmd_lvl;
    logic       hi_any, srv_any;

    assign wr_base = IO_WR_IN && (IO_ADDR_IN == BASE);
    assign wr_data = IO_WR_IN && (IO_ADDR_IN == DATA);
    assign init_w  = wr_base && IO_WDATA_IN[`BIT_INIT];
    assign trig    = (c == 0) ? trig_m_r : trig_s_r;
    assign in_lvl  = (c == 0) ? lvl_r[7:0] : lvl_r[15:8];
    assign in_prev = (c == 0) ? lvl_d_r[7:0] : lvl_d_r[15:8];
    assign cmd_lvl = IO_WDATA_IN[`BIT_SEL_LEVEL] ? IO_WDATA_IN[2:0] : srv_lvl;

    // master line 2 carries the slave output, not its pin
    always_comb
    begin
      lvl_on = in_lvl;
      if (c == 0)
        lvl_on[`CASCADE_LINE] = cpu_from_slave;
    end

    assign edge_hit = lvl_on & ~((c == 0) ? {in_prev[7:3], slave_prev_r, in_prev[1:0]} : in_prev);

    assign req = irr_r & ~mask_r;

    // highest-priority in-service level, the target of a non-specific end of interrupt
    always_comb
    begin
      srv_any = 1'b0;
      srv_lvl = 3'h0;
      for (int k = 0; k < 8; k++)
      begin
        logic [2:0] p;
        p = 3'(low_r + 3'(k) + 3'h1);
        if (!srv_any && isr_r[p])
        begin
          srv_any = 1'b1;
          srv_lvl = p;
        end
      end
    end

    // line after lowest wins; line 0 first by default
    always_comb
    begin
      hi_any = 1'b0;
      hi_lvl = 3'h0;
      for (int k = 0; k < 8; k++)
      begin
        logic [2:0] p;
        p = 3'(low_r + 3'(k) + 3'h1);
        if (!hi_any && req[p] && !(isr_r[p] && !(special_fully_nested_r && c == 0) && !smm_r))
        begin
          hi_any = 1'b1;
          hi_lvl = p;
        end
        // in special mask mode an in-service line blocks neither itself nor lower lines
        if (!smm_r && isr_r[p] && !(special_fully_nested_r && c == 0))
          break;
        if (!smm_r && isr_r[p] && (special_fully_nested_r && c == 0) && !hi_any)
          break;
      end
    end

    assign take_lvl[c]  = hi_lvl;
    assign take_any[c]  = hi_any;
    assign vec_hi[c]    = vbase_r;
    assign poll_read[c] = poll_r && IO_RD_IN && (IO_ADDR_IN == BASE);

    // init sequence and mode bits
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
    begin
      if (!RST_B_IN)
      begin
        st_r      <= ST_RUN;
        mask_r    <= `RESET_MASK;
        vbase_r   <= 5'h00;
        special_fully_nested_r    <= 1'b0;
        automatic_end_of_interrupt_r    <= 1'b0;
        autorot_r <= 1'b0;
        low_r     <= `RESET_LOWEST;
        smm_r     <= 1'b0;
        rsel_r    <= 1'b0;
        poll_r    <= 1'b0;
      end
      else if (init_w)
      begin
        st_r      <= ST_W2;
        mask_r    <= `RESET_MASK;
        low_r     <= `RESET_LOWEST;
        smm_r     <= 1'b0;
        rsel_r    <= 1'b0;
        autorot_r <= 1'b0;
        poll_r    <= 1'b0;
      end
      else
      begin
        if (poll_read[c])
          poll_r <= 1'b0;
        case (st_r)
          ST_W2:
            if (wr_data)
            begin
              vbase_r <= IO_WDATA_IN[7:3];
              st_r    <= ST_W3;
            end
          // cascade wiring is fixed; word 3 only advances the sequence
          ST_W3:
            if (wr_data)
              st_r <= ST_W4;
          ST_W4:
            if (wr_data)
            begin
              special_fully_nested_r <= IO_WDATA_IN[`W4_SPECIAL_FULLY_NESTED_BIT];
              automatic_end_of_interrupt_r <= IO_WDATA_IN[`W4_AUTOMATIC_END_OF_INTERRUPT_BIT];
              st_r   <= ST_RUN;
            end
          ST_RUN:
          begin
            if (wr_data)
              mask_r <= IO_WDATA_IN;
            if (wr_base && IO_WDATA_IN[4:3] == `SEL_EOI_ROTATE)
            begin
              case (IO_WDATA_IN[7:5])
                `CMD_SET_AUTO_ROT: autorot_r <= 1'b1;
                `CMD_CLR_AUTO_ROT: autorot_r <= 1'b0;
                `CMD_ROT_NS_EOI:   if (srv_any) low_r <= srv_lvl;
                `CMD_ROT_SP_EOI:   low_r <= cmd_lvl;
                `CMD_SET_PRIO:     low_r <= cmd_lvl;
                default:           low_r <= low_r;
              endcase
            end
            if (wr_base && IO_WDATA_IN[4:3] == `SEL_READ_SELECT)
            begin
              if (IO_WDATA_IN[`RS_SPECIAL_MASK_ENABLE_BIT])
                smm_r <= IO_WDATA_IN[`RS_SMM_BIT];
              if (IO_WDATA_IN[1])
                rsel_r <= IO_WDATA_IN[0];
              poll_r <= IO_WDATA_IN[`RS_POLL_BIT];
            end
            if (inta_take[c] && automatic_end_of_interrupt_r && autorot_r)
              low_r <= hi_lvl;
          end
          default:
            st_r <= ST_RUN;
        endcase
      end
    end

    // masked lines never latch; a new set wins over the acknowledge clear
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
    begin
      if (!RST_B_IN)
        irr_r <= 8'h00;
      else
        irr_r <= ((irr_r & ~((inta_take[c] ? (8'h01 << hi_lvl) : 8'h00))) & ~(trig & ~lvl_on))
                 | (((edge_hit & ~trig) | (lvl_on & trig)) & ~mask_r);
    end

    // end-of-interrupt clear pattern, decoded apart so the flops below stay non-blocking
    always_comb
    begin
      eoi_clr = 8'h00;
      if (wr_base && IO_WDATA_IN[4:3] == `SEL_EOI_ROTATE && st_r == ST_RUN)
      begin
        if (IO_WDATA_IN[7:5] == `CMD_NS_EOI || IO_WDATA_IN[7:5] == `CMD_ROT_NS_EOI)
          eoi_clr = srv_any ? (8'h01 << srv_lvl) : 8'h00;
        if (IO_WDATA_IN[7:5] == `CMD_SP_EOI || IO_WDATA_IN[7:5] == `CMD_ROT_SP_EOI)
          eoi_clr = 8'h01 << IO_WDATA_IN[2:0];
      end
    end
    // in-service register: set on acknowledge unless automatic end of interrupt is on, cleared by end of interrupt
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
    begin
      if (!RST_B_IN)
        isr_r <= 8'h00;
      else if (init_w)
        isr_r <= 8'h00;
      else
        isr_r <= (isr_r & ~eoi_clr) | ((inta_take[c] && !automatic_end_of_interrupt_r) ? (8'h01 << hi_lvl) : 8'h00);
    end

    // read mux: mask at base+1, status or poll word at base
    always_comb
    begin
      if (IO_ADDR_IN == DATA)
        rd_loc = mask_r;
      else if (poll_r)
        rd_loc = {hi_any, 4'h0, hi_lvl};
      else
        rd_loc = rsel_r ? isr_r : irr_r;
    end
    assign rd_val[c] = rd_loc;
  end

  // slave output onto master line 2, edge-detected on its own history
  // master mask 2 blocks slave
  assign cpu_from_slave = take_any[1];
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      slave_prev_r <= 1'b0;
    else
      slave_prev_r <= cpu_from_slave;
  end

  // acknowledge goes to the master; the slave answers when master picks line 2
  logic m_casc;
  assign m_casc       = take_lvl[0] == `CASCADE_LINE;
  assign inta_take[0] = (INTA_IN || poll_read[0]) && take_any[0];
  assign inta_take[1] = ((INTA_IN && take_any[0] && m_casc) || poll_read[1]) && take_any[1];

  // registered outputs; a read returns one cycle later with a valid pulse
  always_ff @(posedge CLOCK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      IO_RDATA_OUT  <= 8'h00;
      IO_RVALID_OUT <= 1'b0;
      CPU_IRQ_OUT   <= 1'b0;
      VECTOR_OUT    <= 8'h00;
    end
    else
    begin
      IO_RVALID_OUT <= IO_RD_IN | INTA_IN;
      CPU_IRQ_OUT   <= take_any[0];
      if (IO_RD_IN)
      begin
        if (IO_ADDR_IN == `ADDR_MASTER_TRIG)
          IO_RDATA_OUT <= trig_m_r;
        else if (IO_ADDR_IN == `ADDR_SLAVE_TRIG)
          IO_RDATA_OUT <= trig_s_r;
        else if (IO_ADDR_IN[7:4] == 4'hA)
          IO_RDATA_OUT <= rd_val[1];
        else
          IO_RDATA_OUT <= rd_val[0];
      end
      if (INTA_IN)
        VECTOR_OUT <= m_casc ? {vec_hi[1], take_lvl[1]} : {vec_hi[0], take_lvl[0]};
    end
  end

endmodule : cascaded_irq_ctrl

// >>> irq_checker.sv
/*
  Checker for the cascaded interrupt controller pair: io answer timing and fixed trigger bits.
  Assumes it is bound to the top module and that everything runs on the one clock.
*/
`timescale 1ns/1ns
`include "irq_params.svh"
module irq_checker (
  input wire logic        CLOCK_IN,
  input wire logic        RST_B_IN,
  input wire logic [15:0] IO_ADDR_IN,
  input wire logic        IO_WR_IN,
  input wire logic        IO_RD_IN,
  input wire logic        INTA_IN,
  input wire logic [7:0]  IO_RDATA_OUT,
  input wire logic        IO_RVALID_OUT,
  input wire logic        CPU_IRQ_OUT,
  input wire logic [7:0]  VECTOR_OUT
);
  default clocking @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  // answers must follow their strobe by exactly one cycle and never come alone
  a_read_answered : assert property (
    (IO_RD_IN || INTA_IN) |=> IO_RVALID_OUT) else $error("read not answered");
  a_answer_has_cause : assert property (
    IO_RVALID_OUT |-> $past(IO_RD_IN || INTA_IN)) else $error("answer without read");
  a_write_is_silent : assert property (
    (IO_WR_IN && !IO_RD_IN && !INTA_IN) |=> !IO_RVALID_OUT) else $error("write answered");
  a_rdata_holds : assert property (
    (!IO_RD_IN && !INTA_IN) |=> $stable(IO_RDATA_OUT)) else $error("read data moved");
  a_vector_holds : assert property (
    (!INTA_IN && !IO_RD_IN) |=> $stable(VECTOR_OUT)) else $error("vector moved");
  a_reset_quiet : assert property (
    $rose(RST_B_IN) |-> !CPU_IRQ_OUT && !IO_RVALID_OUT) else $error("busy after reset");
  a_master_trig_fixed : assert property (
    (IO_RD_IN && !INTA_IN && IO_ADDR_IN == `ADDR_MASTER_TRIG) |=> IO_RDATA_OUT[2:0] == 3'h0)
    else $error("master edge lines read as level");
  a_slave_trig_fixed : assert property (
    (IO_RD_IN && !INTA_IN && IO_ADDR_IN == `ADDR_SLAVE_TRIG) |=> !IO_RDATA_OUT[5] && !IO_RDATA_OUT[0])
    else $error("slave edge lines read as level");
endmodule : irq_checker

bind cascaded_irq_ctrl irq_checker irq_checker_i (
  .CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN), .IO_ADDR_IN(IO_ADDR_IN), .IO_WR_IN(IO_WR_IN),
  .IO_RD_IN(IO_RD_IN), .INTA_IN(INTA_IN), .IO_RDATA_OUT(IO_RDATA_OUT),
  .IO_RVALID_OUT(IO_RVALID_OUT), .CPU_IRQ_OUT(CPU_IRQ_OUT), .VECTOR_OUT(VECTOR_OUT));

// >>> irq_host.sv
/*
  Host model: issues one-cycle io writes, reads and acknowledges, and the init sequence.
  Assumes strobes are taken on the rising edge and answered one cycle later.
*/
`timescale 1ns/1ns
module irq_host (
  input  wire logic        CLOCK_IN,
  input  wire logic [7:0]  RDATA_IN,
  output logic      [15:0] ADDR_OUT,
  output logic      [7:0]  WDATA_OUT,
  output logic             WR_OUT,
  output logic             RD_OUT,
  output logic             ACK_OUT
);
  initial
  begin
    ADDR_OUT = 16'h0000;
    WDATA_OUT = 8'h00;
    WR_OUT = 1'b0;
    RD_OUT = 1'b0;
    ACK_OUT = 1'b0;
  end

  // released data is inverted so a stale byte can never pass for a fresh one
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLOCK_IN);
    #1;
    ADDR_OUT = a;
    WDATA_OUT = d;
    WR_OUT = 1'b1;
    @(posedge CLOCK_IN);
    #1;
    WR_OUT = 1'b0;
    WDATA_OUT = ~d;
  endtask : wr

  // data is taken one cycle after the strobe, when it has settled
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge CLOCK_IN);
    #1;
    ADDR_OUT = a;
    RD_OUT = 1'b1;
    @(posedge CLOCK_IN);
    #1;
    RD_OUT = 1'b0;
    d = RDATA_IN;
  endtask : rd

  task automatic ack();
    @(posedge CLOCK_IN);
    #1;
    ACK_OUT = 1'b1;
    @(posedge CLOCK_IN);
    #1;
    ACK_OUT = 1'b0;
  endtask : ack

  // four words, low vector bits zero, cascade word
  task automatic init(input logic [15:0] base, input logic [7:0] vec, input logic [7:0] w3);
    wr(base, 8'h11);
    wr(base + 16'h0001, vec);
    wr(base + 16'h0001, w3);
    wr(base + 16'h0001, 8'h01);
  endtask : init
endmodule : irq_host

// >>> tb.sv
/*
  Self-checking bench for the cascaded interrupt controller pair.
  Assumes the host model carries all io traffic and the bench drives the request pins.
*/
`timescale 1ns/1ns
module tb;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] irq = 16'h0000;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  vector;
  logic [7:0]  d;
  logic        wr;
  logic        rd;
  logic        inta;
  logic        rvalid;
  logic        cpu_irq;
  int          miscompares = 0;
  int          compares = 0;
  int          cycles = 0;

  always #20 clock = ~clock;

  cascaded_irq_ctrl cascaded_irq_ctrl_i (.CLOCK_IN(clock), .RST_B_IN(rst_b), .IO_ADDR_IN(addr),
    .IO_WDATA_IN(wdata), .IO_WR_IN(wr), .IO_RD_IN(rd), .INTA_IN(inta), .IRQ_IN(irq),
    .IO_RDATA_OUT(rdata), .IO_RVALID_OUT(rvalid), .CPU_IRQ_OUT(cpu_irq), .VECTOR_OUT(vector));
  irq_host irq_host_i (.CLOCK_IN(clock), .RDATA_IN(rdata), .ADDR_OUT(addr), .WDATA_OUT(wdata),
    .WR_OUT(wr), .RD_OUT(rd), .ACK_OUT(inta));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    irq_host_i.rd(a, d);
    chk(d, exp);
  endtask : rdc

  task automatic ackc(input logic [7:0] exp);
    irq_host_i.ack();
    chk(vector, exp);
  endtask : ackc

  // pins pass a synchroniser, so give them eight cycles to reach the request register
  task automatic pins(input logic [15:0] v);
    @(posedge clock);
    #1;
    irq = v;
    repeat (8) @(posedge clock);
    #1;
  endtask : pins

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // the whole run needs well under two thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (16) @(posedge clock);
    #1;
    rst_b = 1'b1;
    rdc(16'h0021, 8'h00);
    rdc(16'h00A1, 8'h00);
    rdc(16'h04D0, 8'h00);
    rdc(16'h04D1, 8'h00);
    irq_host_i.wr(16'h04D0, 8'hFF);
    rdc(16'h04D0, 8'hF8);
    irq_host_i.wr(16'h04D1, 8'hFF);
    rdc(16'h04D1, 8'hDE);
    irq_host_i.wr(16'h04D0, 8'h00);
    irq_host_i.wr(16'h04D1, 8'h00);
    $display("trigger register test done");
    irq_host_i.init(16'h0020, 8'h08, 8'h04);
    irq_host_i.init(16'h00A0, 8'h70, 8'h02);
    // masked higher lines neither latch nor block the lower one
    irq_host_i.wr(16'h0021, 8'h0A);
    pins(16'h002A);
    ackc(8'h0D);
    rdc(16'h0020, 8'h00);
    irq_host_i.wr(16'h0020, 8'h20);
    pins(16'h0000);
    irq_host_i.wr(16'h0021, 8'h00);
    pins(16'h0022);
    chk({7'h00, cpu_irq}, 8'h01);
    ackc(8'h09);
    irq_host_i.wr(16'h0020, 8'h0B);
    rdc(16'h0020, 8'h02);
    irq_host_i.wr(16'h0020, 8'h20);
    ackc(8'h0D);
    irq_host_i.wr(16'h0020, 8'h20);
    rdc(16'h0020, 8'h00);
    irq_host_i.wr(16'h0020, 8'h0A);
    pins(16'h0000);
    chk({7'h00, cpu_irq}, 8'h00);
    $display("priority test done");
    pins(16'h0010);
    irq_host_i.wr(16'h0020, 8'h0C);
    rdc(16'h0020, 8'h84);
    irq_host_i.wr(16'h0020, 8'h20);
    pins(16'h0000);
    $display("poll test done");
    irq_host_i.wr(16'h04D0, 8'h40);
    pins(16'h0040);
    rdc(16'h0020, 8'h40);
    pins(16'h0000);
    rdc(16'h0020, 8'h00);
    irq_host_i.wr(16'h04D0, 8'h00);
    $display("level test done");
    // an unmapped write that must change nothing, then a restart in mid-sequence
    irq_host_i.wr(16'h0021, 8'hAA);
    irq_host_i.wr(16'h0300, 8'hFF);
    rdc(16'h0021, 8'hAA);
    irq_host_i.wr(16'h0020, 8'h11);
    irq_host_i.wr(16'h0021, 8'h08);
    irq_host_i.init(16'h0020, 8'h08, 8'h04);
    rdc(16'h0021, 8'h00);
    irq_host_i.wr(16'h0021, 8'hF0);
    rdc(16'h0021, 8'hF0);
    irq_host_i.wr(16'h0021, 8'h04);
    $display("restart test done");
    pins(16'h0200);
    chk({7'h00, cpu_irq}, 8'h00);
    rdc(16'h00A0, 8'h02);
    irq_host_i.wr(16'h0021, 8'h00);
    pins(16'h0000);
    // the slave edge came while line 2 was masked, so it stays lost until a fresh request
    chk({7'h00, cpu_irq}, 8'h00);
    irq_host_i.wr(16'h00A0, 8'h0C);
    rdc(16'h00A0, 8'h81);
    irq_host_i.wr(16'h00A0, 8'h20);
    pins(16'h0400);
    chk({7'h00, cpu_irq}, 8'h01);
    ackc(8'h72);
    $display("cascade test done");
    // set priority makes line 4 lowest; a specific end of interrupt for line 5 then lets line 3 through
    irq_host_i.wr(16'h00A0, 8'h20);
    irq_host_i.wr(16'h0020, 8'h20);
    irq_host_i.wr(16'h0020, 8'hC4);
    pins(16'h0028);
    ackc(8'h0D);
    irq_host_i.wr(16'h0020, 8'h65);
    ackc(8'h0B);
    $display("rotate test done");
    wrap_up();
  end
endmodule : tb
